/* core/scda_regs.vh */
// Register map and timing constants for the sampling clock delay adjust block.
// Assumes 24-bit register port addressed by the printed register offsets.
`ifndef SCDA_REGS_VH
`define SCDA_REGS_VH
`define SCDA_ADDR_W 12
`define SCDA_RESULT_OFS 12'h2b2
`define SCDA_MANUAL_OFS 12'h2b5
`define SCDA_DELAY_W 17
`define SCDA_INV_BIT 16
`define SCDA_COARSE_HI 15
`define SCDA_COARSE_LO 8
`define SCDA_FINE_HI 7
`define SCDA_FINE_LO 0
`define SCDA_DONE_BIT 17
`define SCDA_REG_W 24
`define SCDA_MANUAL_RST 17'h00000
`define SCDA_RAMP_PERIOD 384
`define SCDA_RAMP_LAST 9'd383
`define SCDA_RAMP_CNT_W 9
`define SCDA_STEP_SLOW 8'h01
`define SCDA_STEP_FAST 8'h04
`define SCDA_APPLY_MAX 1536
`define SCDA_APPLY_WAIT 11'd1024
`define SCDA_APPLY_CNT_W 11
`define SCDA_CAL_TIME 16'h0100
`define SCDA_CAL_CNT_W 16
`endif

/* core/scda_delay_adjust.v */
// Sampling clock delay adjust: manual delay register, calibration status and
// the applied invert/coarse/fine setting. Assumes all inputs are on clk_sys.
`timescale 1ns/10ps
`include "scda_regs.vh"

module scda_delay_adjust (
	input wire clk_sys,
	input wire rst,
	input wire clk_en,
	input wire [`SCDA_ADDR_W-1:0] reg_addr,
	input wire reg_wr,
	input wire [`SCDA_REG_W-1:0] reg_wdata,
	output reg [`SCDA_REG_W-1:0] reg_rdata,
	input wire ref_cal_enable,
	input wire ramp_enable,
	input wire ramp_fast,
	input wire cal_delay_valid,
	input wire [`SCDA_DELAY_W-1:0] cal_delay_in,
	output reg cal_start,
	output reg clock_invert_out,
	output reg [7:0] coarse_delay_out,
	output reg [7:0] fine_delay_out
);
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_DONE = 2'd2;

	reg [`SCDA_DELAY_W-1:0] manual_q;
	reg [`SCDA_DELAY_W-1:0] result_q;
	reg [1:0] state_q;
	reg en_prev_q;
	reg [`SCDA_CAL_CNT_W-1:0] cal_cnt_q;
	reg [7:0] applied_coarse_q;
	reg [`SCDA_RAMP_CNT_W-1:0] ramp_cnt_q;
	reg [`SCDA_APPLY_CNT_W-1:0] apply_cnt_q;
	reg apply_pend_q;
	reg [1:0] state_d;
	reg [`SCDA_CAL_CNT_W-1:0] cal_cnt_d;
	reg [`SCDA_DELAY_W-1:0] result_d;
	reg [7:0] ramp_next_d;
	reg out_inv_d;
	reg [7:0] out_coarse_d;
	reg [7:0] out_fine_d;

	wire manual_wr = reg_wr && (reg_addr == `SCDA_MANUAL_OFS);
	wire cal_rise = ref_cal_enable && !en_prev_q;
	wire cal_done_flag = ref_cal_enable && (state_q == ST_DONE);
	wire [7:0] target_coarse = manual_q[`SCDA_COARSE_HI:`SCDA_COARSE_LO];
	wire [7:0] step = ramp_fast ? `SCDA_STEP_FAST : `SCDA_STEP_SLOW;
	wire [7:0] diff_up = target_coarse - applied_coarse_q;
	wire [7:0] diff_dn = applied_coarse_q - target_coarse;

	// Register write port
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			manual_q <= `SCDA_MANUAL_RST;
		end else if (clk_en && manual_wr) begin
			manual_q <= reg_wdata[`SCDA_DELAY_W-1:0];
		end
	end

	// Calibration sequencer next state: restarts on enable rising edge
	always @* begin
		state_d = state_q;
		cal_cnt_d = cal_cnt_q;
		result_d = result_q;
		case (state_q)
		ST_IDLE: begin
			if (cal_rise) begin
				state_d = ST_RUN;
				cal_cnt_d = {`SCDA_CAL_CNT_W{1'b0}};
			end
		end
		ST_RUN: begin
			if (!ref_cal_enable) begin
				state_d = ST_IDLE;
			end else if (cal_delay_valid) begin
				result_d = cal_delay_in;
				state_d = ST_DONE;
			end else if (cal_cnt_q == `SCDA_CAL_TIME) begin
				// Engine silent: finish on the previous result
				state_d = ST_DONE;
			end else begin
				cal_cnt_d = cal_cnt_q + 1'b1;
			end
		end
		ST_DONE: begin
			if (!ref_cal_enable) begin
				state_d = ST_IDLE;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	// Calibration sequencer registers
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			en_prev_q <= 1'b0;
			cal_cnt_q <= {`SCDA_CAL_CNT_W{1'b0}};
			result_q <= {`SCDA_DELAY_W{1'b0}};
			cal_start <= 1'b0;
		end else if (clk_en) begin
			en_prev_q <= ref_cal_enable;
			cal_start <= cal_rise;
			state_q <= state_d;
			cal_cnt_q <= cal_cnt_d;
			result_q <= result_d;
		end
	end

	// Next ramp position, clamped so the target is never overshot
	always @* begin
		ramp_next_d = applied_coarse_q;
		if (target_coarse > applied_coarse_q) begin
			if (diff_up < step) begin
				ramp_next_d = target_coarse;
			end else begin
				ramp_next_d = applied_coarse_q + step;
			end
		end else if (target_coarse < applied_coarse_q) begin
			if (diff_dn < step) begin
				ramp_next_d = target_coarse;
			end else begin
				ramp_next_d = applied_coarse_q - step;
			end
		end
	end

	// Applied coarse: ramped or delayed update
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			applied_coarse_q <= 8'h00;
			ramp_cnt_q <= {`SCDA_RAMP_CNT_W{1'b0}};
			apply_cnt_q <= {`SCDA_APPLY_CNT_W{1'b0}};
			apply_pend_q <= 1'b0;
		end else if (clk_en) begin
			if (ramp_enable) begin
				apply_pend_q <= 1'b0;
				if (ramp_cnt_q == `SCDA_RAMP_LAST) begin
					ramp_cnt_q <= {`SCDA_RAMP_CNT_W{1'b0}};
					applied_coarse_q <= ramp_next_d;
				end else begin
					ramp_cnt_q <= ramp_cnt_q + 1'b1;
				end
			end else begin
				ramp_cnt_q <= {`SCDA_RAMP_CNT_W{1'b0}};
				if (manual_wr) begin
					apply_pend_q <= 1'b1;
					apply_cnt_q <= {`SCDA_APPLY_CNT_W{1'b0}};
				end else if (apply_pend_q) begin
					if (apply_cnt_q == `SCDA_APPLY_WAIT) begin
						applied_coarse_q <= target_coarse;
						apply_pend_q <= 1'b0;
					end else begin
						apply_cnt_q <= apply_cnt_q + 1'b1;
					end
				end else begin
					applied_coarse_q <= target_coarse;
				end
			end
		end
	end

	// Source select: calibration result overrides the manual register
	always @* begin
		if (ref_cal_enable) begin
			out_inv_d = result_q[`SCDA_INV_BIT];
			out_coarse_d = result_q[`SCDA_COARSE_HI:`SCDA_COARSE_LO];
			out_fine_d = result_q[`SCDA_FINE_HI:`SCDA_FINE_LO];
		end else begin
			out_inv_d = manual_q[`SCDA_INV_BIT];
			out_coarse_d = applied_coarse_q;
			out_fine_d = manual_q[`SCDA_FINE_HI:`SCDA_FINE_LO];
		end
	end

	// Applied delay outputs, registered so the delay line sees clean steps
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clock_invert_out <= 1'b0;
			coarse_delay_out <= 8'h00;
			fine_delay_out <= 8'h00;
		end else if (clk_en) begin
			clock_invert_out <= out_inv_d;
			coarse_delay_out <= out_coarse_d;
			fine_delay_out <= out_fine_d;
		end
	end

	// Read mux, reserved bits zero
	always @* begin
		reg_rdata = {`SCDA_REG_W{1'b0}};
		if (reg_addr == `SCDA_RESULT_OFS) begin
			reg_rdata = {6'h00, cal_done_flag, result_q};
		end else if (reg_addr == `SCDA_MANUAL_OFS) begin
			reg_rdata = {7'h00, manual_q};
		end
	end
endmodule // scda_delay_adjust

/* sim/scda_delay_adjust_chk.sv */
// Checker for the delay adjust block, bound to its ports.
// Assumes clk_en held high by the bench except for the one gated write in t_freeze.
`timescale 1ns/10ps
module scda_chk (
	input wire clk_sys, rst, clk_en, reg_wr, ref_cal_enable, ramp_enable, ramp_fast,
	input wire cal_delay_valid, cal_start, clock_invert_out,
	input wire [11:0] reg_addr,
	input wire [23:0] reg_wdata, reg_rdata,
	input wire [16:0] cal_delay_in,
	input wire [7:0] coarse_delay_out, fine_delay_out
);
	reg [7:0] tgt_q;
	reg armed_q;
	reg [10:0] late_q;
	wire man_wr = clk_en && reg_wr && reg_addr == 12'h2b5 && !ref_cal_enable;
	always @(posedge clk_sys)
		if (man_wr) tgt_q <= reg_wdata[15:8];
	// Cycles since a plain coarse write that the output still lags the target
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
			late_q <= 11'd0;
		end else begin
			if (ramp_enable || ref_cal_enable)
				armed_q <= 1'b0;
			else if (man_wr)
				armed_q <= 1'b1;
			if (man_wr || !armed_q || coarse_delay_out == tgt_q)
				late_q <= 11'd0;
			else
				late_q <= late_q + 11'd1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_man;
		man_wr ##1 (clk_en && !reg_wr && !ref_cal_enable)[*2];
	endsequence
	sequence s_cal;
		clk_en && ref_cal_enable && cal_delay_valid && reg_addr == 12'h2b2 && !reg_rdata[17];
	endsequence
	AST_RSVD: assert property (reg_addr inside {12'h2b2, 12'h2b5} |->
		reg_rdata[23:18] == 6'h00 && (reg_addr == 12'h2b2 || !reg_rdata[17]))
		else $error("reserved bits set");
	AST_DONE_OFF: assert property (reg_addr == 12'h2b2 && !ref_cal_enable |-> !reg_rdata[17])
		else $error("done without enable");
	AST_START: assert property (clk_en && $rose(ref_cal_enable) |=> cal_start)
		else $error("no start pulse");
	AST_FINE: assert property (s_man |=> fine_delay_out == $past(reg_wdata[7:0], 3))
		else $error("fine not applied");
	AST_INV: assert property (s_man |=> clock_invert_out == $past(reg_wdata[16], 3))
		else $error("invert not applied");
	AST_CAL_RES: assert property (s_cal ##1 reg_addr == 12'h2b2 |->
		reg_rdata[17:0] == {1'b1, $past(cal_delay_in)}) else $error("bad result");
	AST_CAL_OUT: assert property (s_cal ##1 (clk_en && ref_cal_enable)[*3] |->
		{clock_invert_out, coarse_delay_out, fine_delay_out} == $past(cal_delay_in, 3))
		else $error("result not applied");
	AST_COARSE: assert property (late_q < 11'd1536)
		else $error("coarse late");
	AST_RAMP: assert property (ramp_enable && $past(ramp_enable) && !ref_cal_enable &&
		coarse_delay_out != $past(coarse_delay_out) |->
		8'(coarse_delay_out - $past(coarse_delay_out) + (ramp_fast ? 8'h04 : 8'h01))
		<= (ramp_fast ? 8'h08 : 8'h02)) else $error("ramp step too big");
endmodule // scda_chk
bind scda_delay_adjust scda_chk scda_chk_i (.*);

/* sim/tb_top.sv */
// Directed bench for the delay adjust block.
// Assumes the checker is bound by its own file.
`timescale 1ns/10ps
module tb_top;
	reg clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, ref_cal_enable = 1'b0;
	reg ramp_enable = 1'b0, ramp_fast = 1'b0, cal_delay_valid = 1'b0, clk_en = 1'b1;
	reg [11:0] reg_addr = 12'h2b5;
	reg [23:0] reg_wdata = 24'h000000;
	reg [16:0] cal_delay_in = 17'h00000;
	wire [23:0] reg_rdata;
	wire cal_start, clock_invert_out;
	wire [7:0] coarse_delay_out, fine_delay_out;
	integer n_errors = 0, check_count = 0;
	always #5 clk_sys = ~clk_sys;
	scda_delay_adjust scda_delay_adjust_i (.*);
	task step(input integer n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task chk(input [23:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input [11:0] a, input [23:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step(1);
		reg_wr = 1'b0;
	endtask
	task rd(input [11:0] a, input [23:0] e);
		reg_addr = a;
		#1;
		chk(reg_rdata, e);
	endtask
	task outs(input [23:0] e);
		chk({7'h00, clock_invert_out, coarse_delay_out, fine_delay_out}, e);
	endtask
	task t_manual;
		rd(12'h2b5, 24'h000000);
		wr(12'h2b5, 24'hfe1234);
		rd(12'h2b5, 24'h001234);
		step(3);
		outs(24'h000034);
		wr(12'h2b2, 24'hffffff);
		rd(12'h2b2, 24'h000000);
		rd(12'h2b3, 24'h000000);
		wr(12'h2b5, 24'h011256);
		step(1536);
		outs(24'h011256);
	endtask
	task t_ramp;
		ramp_enable = 1'b1;
		wr(12'h2b5, 24'h011456);
		step(1160);
		outs(24'h011456);
		ramp_fast = 1'b1;
		wr(12'h2b5, 24'h011656);
		step(776);
		outs(24'h011656);
		ramp_enable = 1'b0;
	endtask
	task t_cal;
		reg_addr = 12'h2b2;
		ref_cal_enable = 1'b1;
		step(6);
		rd(12'h2b2, 24'h000000);
		cal_delay_in = 17'h1a53c;
		cal_delay_valid = 1'b1;
		step(1);
		cal_delay_valid = 1'b0;
		step(3);
		rd(12'h2b2, 24'h03a53c);
		outs(24'h01a53c);
		wr(12'h2b5, 24'h000000);
		step(3);
		outs(24'h01a53c);
		ref_cal_enable = 1'b0;
		rd(12'h2b2, 24'h01a53c);
		step(1);
		ref_cal_enable = 1'b1;
		step(270);
		rd(12'h2b2, 24'h03a53c);
		ref_cal_enable = 1'b0;
	endtask
	task t_freeze;
		step(1);
		clk_en = 1'b0;
		wr(12'h2b5, 24'h0000aa);
		rd(12'h2b5, 24'h000000);
		chk({16'h0000, fine_delay_out}, 24'h000000);
		clk_en = 1'b1;
		wr(12'h2b5, 24'h0000aa);
		step(1);
		chk({16'h0000, fine_delay_out}, 24'h0000aa);
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		step(2);
		rst = 1'b0;
		t_manual;
		t_ramp;
		t_cal;
		t_freeze;
		report_and_stop;
	end
	initial begin
		#100000;
		n_errors++;
		report_and_stop;
	end
endmodule // tb_top
